/* File: ssrb_format.sv */
/*
  Turns a stored record into the byte at one position of the record.
  Assumes the position is below the record length; others read zero.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrb_format
  import ssrb_pkg::*;
(
  ssrb_rec_if.fmt          rec_bus,  // Record to format
  input  wire logic [5:0]  pos,      // Byte position
  output logic      [7:0]  data      // Byte at that position
);
  logic [7:0] b [REC_BYTES];

  always_comb begin
    for (int k = 0; k < REC_BYTES; k++) begin
      b[k] = 8'h00;
    end
    b[B_CODE] = {rec_bus.rec.valid, rec_bus.rec.deferred ?
                 CODE_DEFERRED : CODE_CURRENT};
    b[B_KEY] = {2'b00, rec_bus.rec.incorrect_length_flag, 1'b0,
                rec_bus.rec.key};
    b[B_ADDL] = ADDL_LEN;
    b[B_ASC] = rec_bus.rec.asc;
    b[B_ASCQ] = rec_bus.rec.ascq;
    b[B_SKS] = {rec_bus.rec.key_specific_valid,
                rec_bus.rec.sks[22:16]};
    b[B_SKS + 1] = rec_bus.rec.sks[15:8];
    b[B_SKS + 2] = rec_bus.rec.sks[7:0];
    // Multi-byte fields go out most significant byte first
    for (int k = 0; k < W4; k++) begin
      b[B_INFO + k] = rec_bus.rec.info[8 * (W4 - 1 - k) +: 8];
      b[B_CSI + k]  = rec_bus.rec.csi[8 * (W4 - 1 - k) +: 8];
      b[B_VEND + k] = rec_bus.rec.vendor[8 * (W4 - 1 - k) +: 8];
    end
    for (int k = 0; k < W6; k++) begin
      b[B_PROD + k] = rec_bus.rec.prod[8 * (W6 - 1 - k) +: 8];
    end
    data = (pos < REC_LIMIT) ? b[pos[4:0]] : 8'h00;
  end
endmodule : ssrb_format
`default_nettype wire

/* File: ssrb_irq.sv */
/*
  Sticky event status, mask and the level interrupt.
  Assumes events are one-cycle pulses; write one to a status bit clears it.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrb_irq
  import ssrb_pkg::*;
(
  input  wire logic              clk,       // Clock
  input  wire logic              arst_n,    // Async reset, active low
  input  wire logic [STAT_W-1:0] events,    // Event pulses
  input  wire logic              wr_status, // Write-one-to-clear strobe
  input  wire logic              wr_mask,   // Mask write strobe
  input  wire logic [STAT_W-1:0] wdata,     // Write data
  output logic      [STAT_W-1:0] status,    // Sticky status
  output logic      [STAT_W-1:0] mask,      // Interrupt enables
  output logic                   irq        // Level interrupt
);
  logic [STAT_W-1:0] next_status;

  // Set wins over a clear in the same cycle
  assign next_status = (status & ~(wr_status ? wdata : '0)) | events;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & (wr_mask ? wdata : mask));
    end
  end
endmodule : ssrb_irq
`default_nettype wire

/* File: ssrb_pkg.sv */
/*
  Shared constants and types of the sense record builder.
  Assumes one clock domain and a byte-wide sense stream.
*/
package ssrb_pkg;
  localparam int          NEXUS_COUNT   = 4;
  localparam int          NEXUS_W       = 2;
  localparam int          REC_BYTES     = 32;
  localparam int          POS_W         = 6;
  localparam logic [5:0]  REC_LIMIT     = 6'h20;
  localparam logic [7:0]  ADDL_LEN      = 8'h18;
  localparam logic [6:0]  CODE_CURRENT  = 7'h70;
  localparam logic [6:0]  CODE_DEFERRED = 7'h71;
  localparam logic [7:0]  OP_READ_LONG  = 8'h3E;
  localparam logic [7:0]  OP_WRITE_LONG = 8'h3F;
  localparam logic [3:0]  KEY_NONE      = 4'h0;
  localparam logic [3:0]  KEY_RECOVERED = 4'h1;
  localparam logic [3:0]  KEY_UNIT_ATTN = 4'h6;
  localparam logic [3:0]  KEY_ILLEGAL   = 4'h5;
  localparam logic [3:0]  KEY_ABORTED   = 4'hB;
  // Byte positions inside the record
  localparam int          B_CODE = 0;
  localparam int          B_KEY  = 2;
  localparam int          B_INFO = 3;
  localparam int          B_ADDL = 7;
  localparam int          B_CSI  = 8;
  localparam int          B_ASC  = 12;
  localparam int          B_ASCQ = 13;
  localparam int          B_UNIT = 14;
  localparam int          B_SKS  = 15;
  localparam int          B_VEND = 20;
  localparam int          B_PROD = 24;
  localparam int          W4     = 4;
  localparam int          W6     = 6;
  // Register map, byte addresses
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_MASK   = 8'h04;
  localparam logic [7:0]  REG_CTRL   = 8'h08;
  localparam logic [7:0]  REG_STATE  = 8'h0C;
  localparam int          STAT_W     = 3;
  localparam int          ST_STORED  = 0;
  localparam int          ST_REJECT  = 1;
  localparam int          ST_SENT    = 2;
  localparam int          CT_CLEAR   = 0;
  localparam int          CT_ACCEPT  = 1;
  localparam logic [1:0]  CTRL_RESET = 2'h3;

  typedef struct packed {
    logic        valid;
    logic        deferred;
    logic        incorrect_length_flag;
    logic [3:0]  key;
    logic [31:0] info;
    logic [31:0] csi;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic        key_specific_valid;
    logic [22:0] sks;
    logic [31:0] vendor;
    logic [47:0] prod;
  } ssrb_rec_type;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} ssrb_state_type;

  function automatic logic ssrb_legal_key(input logic [3:0] k);
    return (k <= KEY_UNIT_ATTN) || (k == KEY_ABORTED);
  endfunction : ssrb_legal_key

  function automatic logic ssrb_long_op(input logic [7:0] op);
    return (op == OP_READ_LONG) || (op == OP_WRITE_LONG);
  endfunction : ssrb_long_op
endpackage : ssrb_pkg

/* File: ssrb_rec_if.sv */
/*
  Carries the record being sent from the control logic to the formatter.
  Assumes the record holds still while a transfer runs.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssrb_rec_if;
  import ssrb_pkg::*;
  ssrb_rec_type rec;
  modport src (output rec);
  modport fmt (input rec);
endinterface : ssrb_rec_if
`default_nettype wire

/* File: ssrb_sink.sv */
/*
  Initiator-side sink for the sense stream: stalls every fourth cycle,
  collects the bytes it takes and flags the final one.
  Assumes one clock; clear is a one-cycle pulse from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrb_sink (
  input  wire logic       clk,         // Clock
  input  wire logic       arst_n,      // Async reset, low
  input  wire logic       clear,       // Restart collection
  input  wire logic [7:0] sense_data,  // Record byte
  input  wire logic       sense_valid, // Byte valid
  input  wire logic       sense_last,  // Final byte
  output logic            out_ready,   // Take byte
  output logic [7:0]      rx [32],     // Collected bytes
  output logic [5:0]      count,       // Bytes taken
  output logic            got_last     // Final byte seen
);
  logic [1:0] cyc;

  // Periodic stall, one cycle in four, so the source must hold a byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc       <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      cyc       <= cyc + 2'h1;
      out_ready <= (cyc != 2'h3);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count    <= 6'h00;
      got_last <= 1'b0;
    end else if (clear) begin
      count    <= 6'h00;
      got_last <= 1'b0;
    end else if (sense_valid && out_ready) begin
      count <= count + 6'h01;
      if (sense_last) begin
        got_last <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!clear && sense_valid && out_ready) begin
      rx[count[4:0]] <= sense_data;
    end
  end
endmodule : ssrb_sink
`default_nettype wire

/* File: ssrb_tb.sv */
/*
  Self-checking bench of the sense record builder.
  Assumes the sink model and the design sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssrb_pkg::*;
  logic clk = 0, arst_n = 0, ev_valid = 0, ev_deferred = 0, ev_recovered = 0;
  logic ev_invalid_unit = 0, ev_cdb_field = 0, ev_lba_valid = 0;
  logic ev_sks_valid = 1, rs_start = 0, reg_wr = 0, reg_rd = 0, clr = 0;
  logic [1:0] ev_nexus = 0, rs_nexus = 0;
  logic [3:0] ev_key = 0;
  logic [7:0] ev_opcode = 0, ev_asc = 8'h17, ev_ascq = 8'h06, rs_alloc = 0;
  logic [7:0] reg_addr = 0, sense_data, rx [32];
  logic [31:0] ev_lba = 0, ev_req_len = 0, ev_act_len = 0, reg_wdata = 0;
  logic [31:0] ev_csi = 32'hA1B2C3D4, ev_vendor = 32'h5E6F7081, reg_rdata, d;
  logic [22:0] ev_sks = 23'h2A5C3E;
  logic [47:0] ev_prod = 48'h9192A3B4C5D6;
  logic [3:0] queue_hold;
  logic [5:0] count;
  logic sense_valid, sense_last, medium_guard, irq, out_ready, got_last;
  int mg_count = 0;
  int miscompares = 0, tests_run = 0, cycles = 0;
  logic [3:0] keys [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hB,
                            4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};

  ssrb_top ssrb_top_inst (.clk(clk), .arst_n(arst_n), .ev_valid(ev_valid),
    .ev_nexus(ev_nexus), .ev_deferred(ev_deferred), .ev_key(ev_key),
    .ev_recovered(ev_recovered), .ev_invalid_unit(ev_invalid_unit),
    .ev_cdb_field(ev_cdb_field), .ev_opcode(ev_opcode),
    .ev_lba_valid(ev_lba_valid), .ev_lba(ev_lba), .ev_req_len(ev_req_len),
    .ev_act_len(ev_act_len), .ev_csi(ev_csi), .ev_asc(ev_asc),
    .ev_ascq(ev_ascq), .ev_sks_valid(ev_sks_valid), .ev_sks(ev_sks),
    .ev_vendor(ev_vendor), .ev_prod(ev_prod), .rs_start(rs_start),
    .rs_nexus(rs_nexus), .rs_alloc(rs_alloc), .out_ready(out_ready),
    .sense_data(sense_data), .sense_valid(sense_valid),
    .sense_last(sense_last), .queue_hold(queue_hold),
    .medium_guard(medium_guard), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  ssrb_sink ssrb_sink_inst (.clk(clk), .arst_n(arst_n), .clear(clr),
    .sense_data(sense_data), .sense_valid(sense_valid),
    .sense_last(sense_last), .out_ready(out_ready), .rx(rx), .count(count),
    .got_last(got_last));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (medium_guard === 1'b1) mg_count <= mg_count + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] exp_b(input int i);
    logic lng;
    logic [255:0] r;
    lng = (ev_opcode == OP_READ_LONG || ev_opcode == OP_WRITE_LONG) &&
          (ev_req_len != ev_act_len);
    r = {lng | ev_lba_valid, ev_deferred ? CODE_DEFERRED : CODE_CURRENT,
         8'h00, 2'h0, lng, 1'b0, ev_recovered ? 4'h1 : ev_key,
         lng ? ev_req_len - ev_act_len : ev_lba, ADDL_LEN, ev_csi, ev_asc,
         ev_ascq, 8'h00, ev_sks_valid, ev_sks, 16'h0000, ev_vendor, ev_prod,
         16'h0000};
    return r[255 - 8 * i -: 8];
  endfunction : exp_b

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rep(input logic [1:0] n, input logic [3:0] k,
                     input logic [7:0] op, input logic [31:0] rq, ac);
    @(posedge clk);
    ev_valid   <= 1'b1;
    ev_nexus   <= n;
    ev_key     <= k;
    ev_opcode  <= op;
    ev_req_len <= rq;
    ev_act_len <= ac;
    ev_lba     <= 32'h00ABCD10 + 32'(k);
    @(posedge clk);
    ev_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rep

  task automatic fetch(input logic [1:0] n, input logic [7:0] alloc);
    @(posedge clk);
    clr      <= 1'b1;
    rs_start <= 1'b1;
    rs_nexus <= n;
    rs_alloc <= alloc;
    @(posedge clk);
    clr      <= 1'b0;
    rs_start <= 1'b0;
    // Let the sink's clear land before trusting its last flag
    @(posedge clk);
    for (int i = 0; i < 300 && got_last !== 1'b1; i++) @(posedge clk);
    chk({26'h0, count}, {24'h0, alloc}, "byte count");
    repeat (2) @(posedge clk);
  endtask : fetch

  task automatic cmp_rec();
    for (int i = 0; i < REC_BYTES; i++)
      chk({24'h0, rx[i]}, {24'h0, exp_b(i)}, "record byte");
  endtask : cmp_rec

  task automatic t_regs();
    rd(REG_STATUS, d);
    chk(d, 32'h0, "status reset");
    rd(REG_MASK, d);
    chk(d, 32'h0, "mask reset");
    wr(8'h10, 32'hFFFFFFFF);
    rd(REG_CTRL, d);
    chk(d, 32'h3, "ctrl reset");
    rd(8'h10, d);
    chk(d, 32'h0, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_record();
    ev_lba_valid <= 1'b1;
    rep(2'h0, 4'h3, 8'h28, 32'd512, 32'd512);
    chk({28'h0, queue_hold}, 32'h1, "hold set");
    fetch(2'h0, 8'h20);
    cmp_rec();
    chk({28'h0, queue_hold}, 32'h0, "hold cleared");
    rd(REG_STATUS, d);
    chk(d, 32'h5, "stored and sent");
    fetch(2'h0, 8'h08);
    chk({24'h0, rx[0]}, 32'h70, "cleared byte0");
    chk({24'h0, rx[7]}, 32'h18, "cleared byte7");
    $display("test record done");
  endtask : t_record

  task automatic t_length();
    logic [7:0] ops [3] = '{8'h3E, 8'h3F, 8'h28};
    logic [31:0] rqs [3] = '{32'd10, 32'd20, 32'd10};
    for (int i = 0; i < 3; i++) begin
      ev_deferred  <= (i != 1);
      ev_recovered <= (i == 2);
      ev_lba_valid <= 1'b0;
      rep(2'h0, 4'h3, ops[i], rqs[i], 32'd12);
      fetch(2'h0, 8'h20);
      cmp_rec();
    end
    ev_deferred  <= 1'b0;
    ev_recovered <= 1'b0;
    $display("test length done");
  endtask : t_length

  task automatic t_keys();
    for (int i = 0; i < 16; i++) begin
      wr(REG_STATUS, 32'h7);
      rep(2'h3, keys[i], 8'h28, 32'd1, 32'd1);
      rd(REG_STATUS, d);
      chk(d, (i < 8) ? 32'h1 : 32'h2, "key accepted");
      if (i < 8) begin
        fetch(2'h3, 8'h03);
        chk({24'h0, rx[2]}, {28'h0, keys[i]}, "key byte");
      end
    end
    $display("test keys done");
  endtask : t_keys

  task automatic t_guard();
    int base;
    for (int i = 0; i < 2; i++) begin
      ev_cdb_field <= (i == 0);
      base = mg_count;
      rep(2'h1, KEY_ILLEGAL, 8'h2A, 32'd1, 32'd1);
      chk(mg_count - base, (i == 0) ? 32'h1 : 32'h0, "guard");
    end
    ev_cdb_field <= 1'b0;
    fetch(2'h1, 8'h01);
    ev_invalid_unit <= 1'b1;
    rep(2'h1, 4'h5, 8'h2A, 32'd1, 32'd1);
    chk({28'h0, queue_hold}, 32'h0, "no hold");
    ev_invalid_unit <= 1'b0;
    fetch(2'h1, 8'h01);
    $display("test guard done");
  endtask : t_guard

  task automatic t_nexus();
    rep(2'h2, 4'h4, 8'h28, 32'd1, 32'd1);
    rep(2'h1, 4'h2, 8'h28, 32'd1, 32'd1);
    chk({28'h0, queue_hold}, 32'h6, "two holds");
    rd(REG_STATE, d);
    chk(d, 32'hC, "state holds");
    fetch(2'h2, 8'h03);
    chk({24'h0, rx[2]}, 32'h04, "nexus two key");
    fetch(2'h1, 8'h20);
    cmp_rec();
    $display("test nexus done");
  endtask : t_nexus

  task automatic t_irq();
    wr(REG_STATUS, 32'h7);
    wr(REG_MASK, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq idle");
    rep(2'h0, 4'h2, 8'h28, 32'd1, 32'd1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(REG_MASK, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(REG_MASK, 32'h1);
    wr(REG_STATUS, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    fetch(2'h0, 8'h00);
    chk({28'h0, queue_hold}, 32'h0, "zero alloc hold");
    $display("test irq done");
  endtask : t_irq

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_record();
    t_length();
    t_keys();
    t_guard();
    t_nexus();
    t_irq();
    conclude();
  end
endmodule : testbench
`default_nettype wire

/* File: ssrb_top.sv */
/*
  Sense record builder: keeps one record per nexus, fills it from error
  reports, and streams it out for a sense request.
  Assumes all inputs are synchronous to clk and report pulses last one cycle.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ssrb_top
  import ssrb_pkg::*;
(
  input  wire logic               clk,             // 100 MHz clock
  input  wire logic               arst_n,          // Async reset, low
  input  wire logic               ev_valid,        // Error report pulse
  input  wire logic [NEXUS_W-1:0] ev_nexus,        // Nexus of report
  input  wire logic               ev_deferred,     // Earlier command
  input  wire logic [3:0]         ev_key,          // Category key
  input  wire logic               ev_recovered,    // Done after recovery
  input  wire logic               ev_invalid_unit, // Bad unit, no hold
  input  wire logic               ev_cdb_field,    // Bad command field
  input  wire logic [7:0]         ev_opcode,       // Command opcode
  input  wire logic               ev_lba_valid,    // Address is valid
  input  wire logic [31:0]        ev_lba,          // Block address
  input  wire logic [31:0]        ev_req_len,      // Requested length
  input  wire logic [31:0]        ev_act_len,      // Stored length
  input  wire logic [31:0]        ev_csi,          // Command specific
  input  wire logic [7:0]         ev_asc,          // Additional code
  input  wire logic [7:0]         ev_ascq,         // Code qualifier
  input  wire logic               ev_sks_valid,    // Key-specific valid
  input  wire logic [22:0]        ev_sks,          // Key-specific bits
  input  wire logic [31:0]        ev_vendor,       // Vendor error info
  input  wire logic [47:0]        ev_prod,         // Product info
  input  wire logic               rs_start,        // Sense request pulse
  input  wire logic [NEXUS_W-1:0] rs_nexus,        // Requesting nexus
  input  wire logic [7:0]         rs_alloc,        // Allocation length
  input  wire logic               out_ready,       // Sink takes byte
  output logic      [7:0]         sense_data,      // Record byte
  output logic                    sense_valid,     // Byte valid
  output logic                    sense_last,      // Final byte
  output logic [NEXUS_COUNT-1:0]  queue_hold,      // Queue suspended
  output logic                    medium_guard,    // End, no medium write
  input  wire logic [7:0]         reg_addr,        // Register address
  input  wire logic [31:0]        reg_wdata,       // Write data
  input  wire logic               reg_wr,          // Write strobe
  input  wire logic               reg_rd,          // Read strobe
  output logic      [31:0]        reg_rdata,       // Read data
  output logic                    irq              // Interrupt level
);
  ssrb_state_type      state;
  ssrb_rec_type        rec [NEXUS_COUNT];
  ssrb_rec_type        cur_rec;
  ssrb_rec_type        new_rec;
  logic [NEXUS_W-1:0]  cur_nexus;
  logic [POS_W-1:0]    idx;
  logic [POS_W-1:0]    limit;
  logic [POS_W-1:0]    out_pos;
  logic [7:0]          fmt_byte;
  logic [1:0]          ctrl;
  logic [STAT_W-1:0]   status;
  logic [STAT_W-1:0]   mask;
  logic [3:0]          key_eff;
  logic                accept;
  logic                store;
  logic                load_byte;
  logic                done_evt;
  logic                len_flag;

  ssrb_rec_if rec_bus ();
  assign rec_bus.rec = cur_rec;

  ssrb_format u_format (
    .rec_bus (rec_bus),
    .pos     (idx),
    .data    (fmt_byte)
  );

  assign key_eff = ev_recovered ? KEY_RECOVERED : ev_key;
  // Unlisted keys never enter a record; they show as a reject event
  assign accept = ctrl[CT_ACCEPT] && ssrb_legal_key(key_eff);
  assign store = ev_valid && accept;
  assign len_flag = ssrb_long_op(ev_opcode) &&
                    (ev_req_len != ev_act_len);

  always_comb begin
    new_rec = '0;
    new_rec.deferred = ev_deferred;
    new_rec.incorrect_length_flag = len_flag;
    new_rec.valid = len_flag || ev_lba_valid;
    new_rec.key = key_eff;
    // Residue wraps naturally into two's complement
    new_rec.info = len_flag ? (ev_req_len - ev_act_len) : ev_lba;
    new_rec.csi = ev_csi;
    new_rec.asc = ev_asc;
    new_rec.ascq = ev_ascq;
    new_rec.key_specific_valid = ev_sks_valid;
    new_rec.sks = ev_sks;
    new_rec.vendor = ev_vendor;
    new_rec.prod = ev_prod;
  end

  assign load_byte = (state == ST_SEND) && (idx < limit) &&
                     (!sense_valid || out_ready);
  assign done_evt = ((state == ST_SEND) && sense_valid && sense_last &&
                     out_ready) || ((state == ST_LOAD) && (limit == '0));

  // A new report for the nexus being sent beats the clear after reading
  for (genvar g = 0; g < NEXUS_COUNT; g++) begin : g_nexus
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rec[g] <= '0;
      end else if (store && (ev_nexus == g)) begin
        rec[g] <= new_rec;
      end else if (done_evt && ctrl[CT_CLEAR] && (cur_nexus == g)) begin
        rec[g] <= '0;
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        queue_hold[g] <= 1'b0;
      end else if (store && !ev_invalid_unit && (ev_nexus == g)) begin
        queue_hold[g] <= 1'b1;
      end else if (done_evt && (cur_nexus == g)) begin
        queue_hold[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      medium_guard <= 1'b0;
    end else begin
      medium_guard <= store && (key_eff == KEY_ILLEGAL) && ev_cdb_field;
    end
  end

  // Requests arriving mid-transfer are ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cur_nexus <= '0;
      limit <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rs_start) begin
            state <= ST_LOAD;
            cur_nexus <= rs_nexus;
            limit <= (rs_alloc >= 8'(REC_LIMIT)) ? REC_LIMIT :
                     rs_alloc[POS_W-1:0];
          end
        end
        ST_LOAD: begin
          state <= (limit == '0) ? ST_IDLE : ST_SEND;
        end
        ST_SEND: begin
          if (done_evt) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Snapshot so a report landing mid-transfer cannot tear the record
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_rec <= '0;
    end else if (state == ST_IDLE && rs_start) begin
      cur_rec <= rec[rs_nexus];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx <= '0;
      out_pos <= '0;
      sense_data <= 8'h00;
      sense_valid <= 1'b0;
      sense_last <= 1'b0;
    end else if (state == ST_LOAD) begin
      idx <= '0;
    end else if (load_byte) begin
      sense_data <= fmt_byte;
      out_pos <= idx;
      sense_valid <= 1'b1;
      sense_last <= (idx == limit - 6'h01);
      idx <= idx + 6'h01;
    end else if (out_ready) begin
      sense_valid <= 1'b0;
      sense_last <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  ssrb_irq u_irq (
    .clk       (clk),
    .arst_n    (arst_n),
    .events    ({done_evt, ev_valid && !accept, store}),
    .wr_status (reg_wr && reg_addr == REG_STATUS),
    .wr_mask   (reg_wr && reg_addr == REG_MASK),
    .wdata     (reg_wdata[STAT_W-1:0]),
    .status    (status),
    .mask      (mask),
    .irq       (irq)
  );

  // Unmapped addresses read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: reg_rdata <= 32'(status);
        REG_MASK:   reg_rdata <= 32'(mask);
        REG_CTRL:   reg_rdata <= 32'(ctrl);
        REG_STATE:  reg_rdata <= 32'({queue_hold, state != ST_IDLE});
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_code_byte: assert property (sense_valid && out_pos == 6'(B_CODE)
    |-> sense_data[6:0] == (cur_rec.deferred ? CODE_DEFERRED
                            : CODE_CURRENT))
    else $error("error code byte wrong");
  a_valid_bit: assert property (store && !len_flag && !ev_lba_valid
    |=> !rec[$past(ev_nexus)].valid)
    else $error("valid bit set without address");
  a_defer_kept: assert property (store && ev_deferred
    |=> rec[$past(ev_nexus)].deferred)
    else $error("deferred flag lost");
  a_length_long: assert property (store && new_rec.incorrect_length_flag
    |-> ssrb_long_op(ev_opcode))
    else $error("length flag on other command");
  a_length_valid: assert property (new_rec.incorrect_length_flag
    |-> new_rec.valid && ev_req_len != ev_act_len)
    else $error("length flag without valid");
  a_key_legal: assert property (store
    |-> ssrb_legal_key(new_rec.key))
    else $error("unlisted key stored");
  a_recov_key: assert property (store && ev_recovered
    |=> rec[$past(ev_nexus)].key == KEY_RECOVERED)
    else $error("recovered key missing");
  a_guard_pulse: assert property (store && key_eff == KEY_ILLEGAL &&
    ev_cdb_field |=> medium_guard)
    else $error("medium guard not raised");
  a_info_lba: assert property (store && !len_flag
    |=> rec[$past(ev_nexus)].info == $past(ev_lba))
    else $error("address not stored");
  a_info_resid: assert property (store && len_flag
    |-> new_rec.info == ev_req_len - ev_act_len)
    else $error("residue wrong");
  a_addl_len: assert property (sense_valid && out_pos == 6'(B_ADDL)
    |-> sense_data == ADDL_LEN)
    else $error("additional length wrong");
  a_asc_byte: assert property (sense_valid && out_pos == 6'(B_ASC)
    |-> sense_data == cur_rec.asc)
    else $error("additional code wrong");
  a_unit_zero: assert property (sense_valid && out_pos == 6'(B_UNIT)
    |-> sense_data == 8'h00)
    else $error("reserved byte not zero");
  a_byte_order: assert property (sense_valid && out_ready && !sense_last
    |=> sense_valid && out_pos == $past(out_pos) + 6'h01)
    else $error("bytes out of order");
  a_trunc_len: assert property (sense_valid && sense_last
    |-> out_pos == limit - 6'h01)
    else $error("record not cut at allocation");
  a_hold_set: assert property (store && !ev_invalid_unit
    |=> queue_hold[$past(ev_nexus)])
    else $error("queue not held");
  a_req_answer: assert property (state == ST_IDLE && rs_start &&
    rs_alloc != 8'h00 ##1 out_ready [*2] |=> sense_valid)
    else $error("sense request not answered");

  c_full_record: cover property (sense_valid && sense_last &&
                                 out_pos == REC_LIMIT - 6'h01);
  c_zero_alloc: cover property (state == ST_LOAD && limit == '0);
  c_deferred: cover property (store && ev_deferred);
  c_length_store: cover property (store && len_flag);
endmodule : ssrb_top
`default_nettype wire
